// ### rtl/flash_protect_pkg.sv
// constants for the flash block protection and security logic
package flash_protect_pkg;
    localparam int num_blocks = 8;
    localparam int block_kbytes = 128;
    localparam logic [31:0] security_mode_addr = 32'hffffe510;
    localparam logic [31:0] security_key_addr = 32'hffffe514;
    localparam logic [31:0] protect_status_addr = 32'hffffe518;
    localparam logic [31:0] status_addr = 32'hffffe51c;
    localparam logic [15:0] addr_low_mask = 16'hffff;
    localparam int security_enable_pos = 0;
    localparam logic security_enable_reset = 1'h1;
    localparam logic [31:0] security_key_value = 32'h000000c5;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam int st_secure_pos = 0;
    localparam int st_all_prot_pos = 1;
    localparam int st_probe_en_pos = 2;
    localparam int st_prog_rd_pos = 3;
endpackage

// ### rtl/protect_store.sv
// non-volatile model of the eight block protect cells
`timescale 1ns/1ps
module protect_store #(
    parameter int blocks = 8
) (
    // clock and control
    input wire logic aclk,
    input wire logic aclken,
    // cell power-up image and updates
    input wire logic [blocks-1:0] nv_image,
    input wire logic load_image,
    input wire logic [blocks-1:0] set_mask,
    input wire logic [blocks-1:0] clear_mask,
    // cell contents
    output logic [blocks-1:0] protect_bits
);
    typedef struct packed {
        logic [blocks-1:0] cells;
    } store_state_t;
    store_state_t state;
    store_state_t next_state;

    // cells keep no reset: their image is reloaded at power-up
    always_comb begin
        next_state = state;
        for (int i = 0; i < blocks; i++) begin
            if (load_image) begin
                next_state.cells[i] = nv_image[i];
            end else if (set_mask[i]) begin
                next_state.cells[i] = 1'b1;
            end else if (clear_mask[i]) begin
                next_state.cells[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (aclken) begin
            state <= next_state;
        end
    end

    assign protect_bits = state.cells;
endmodule // protect_store

// ### rtl/flash_block_protect_security.sv
// flash block protection and security control with axi4-lite registers
`timescale 1ns/1ps
module flash_block_protect_security #(
    parameter int blocks = flash_protect_pkg::num_blocks
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // non-volatile image of protect cells at power-up
    input wire logic [blocks-1:0] nv_protect_image,
    // from the flash command sequencer
    input wire logic protect_cmd,
    input wire logic unprotect_all_cmd,
    input wire logic [blocks-1:0] cmd_block_sel,
    input wire logic program_req,
    input wire logic erase_req,
    input wire logic chip_erase_req,
    // to the flash array
    output logic [blocks-1:0] program_enable,
    output logic [blocks-1:0] erase_enable,
    output logic op_refused,
    // access gates
    input wire logic programmer_mode,
    output logic programmer_read_enable,
    output logic probe_access_enable,
    output logic secure_state,
    // dedicated debug probe pins
    input wire logic probe_tdi,
    input wire logic probe_tms,
    output logic probe_tdo,
    output logic probe_tdo_oe,
    output logic probe_tdi_core,
    output logic probe_tms_core,
    input wire logic probe_tdo_core
);
    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic awhave;
        logic [31:0] awaddr;
        logic whave;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic security_enable_bit;
        logic secure;
        logic powered_up;
        logic [blocks-1:0] program_enable;
        logic [blocks-1:0] erase_enable;
        logic op_refused;
    } ctrl_state_t;
    ctrl_state_t state;
    ctrl_state_t next_state;

    logic [blocks-1:0] protect_bits;
    logic [blocks-1:0] set_mask;
    logic [blocks-1:0] clear_mask;
    logic all_protected;
    logic load_image;
    logic aw_hit;
    logic w_hit;
    logic do_write;

    // ********************************************************
    // protect cells
    // ********************************************************
    // load happens in the first enabled cycle after reset release
    assign load_image = !state.powered_up;

    protect_store #(
        .blocks(blocks)
    ) u_store (
        .aclk(aclk),
        .aclken(aclken),
        .nv_image(nv_protect_image),
        .load_image(load_image),
        .set_mask(set_mask),
        .clear_mask(clear_mask),
        .protect_bits(protect_bits)
    );

    // per-block protect command; a protected block cannot be unprotected
    // while the flash is secure, else the lock would be trivial
    generate
        for (genvar g = 0; g < blocks; g++) begin : g_blk
            assign set_mask[g] = protect_cmd && cmd_block_sel[g];
            assign clear_mask[g] = unprotect_all_cmd && !state.secure;
        end
    endgenerate

    assign all_protected = &protect_bits;

    // ********************************************************
    // bus decode
    // ********************************************************
    assign aw_hit = state.awhave || s_axi_awvalid;
    assign w_hit = state.whave || s_axi_wvalid;
    assign do_write = aw_hit && w_hit && !state.bvalid;
    // a frozen block must not finish a handshake it cannot record
    assign s_axi_awready = aclken && !state.awhave && !state.bvalid;
    assign s_axi_wready = aclken && !state.whave && !state.bvalid;
    assign s_axi_arready = aclken && !state.rvalid;

    always_comb begin
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        waddr = state.awhave ? state.awaddr : s_axi_awaddr;
        wdata = state.whave ? state.wdata : s_axi_wdata;
        wstrb = state.whave ? state.wstrb : s_axi_wstrb;
        next_state = state;

        // ----- write channel -----
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.awhave = 1'b1;
            next_state.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.whave = 1'b1;
            next_state.wdata = s_axi_wdata;
            next_state.wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            next_state.awhave = 1'b0;
            next_state.whave = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = flash_protect_pkg::resp_okay;
            if (waddr == flash_protect_pkg::security_mode_addr) begin
                if (wstrb[0]) begin
                    next_state.security_enable_bit =
                        wdata[flash_protect_pkg::security_enable_pos];
                end
            end else if (waddr == flash_protect_pkg::security_key_addr) begin
                // key must arrive whole; partial strobes do not count
                if (wstrb == 4'hf &&
                    wdata == flash_protect_pkg::security_key_value) begin
                    // enable bit decides direction; only power-up with a cell unprotected also unlocks
                    next_state.secure = state.security_enable_bit;
                end // other values ignored
            end else if (waddr == flash_protect_pkg::protect_status_addr ||
                         waddr == flash_protect_pkg::status_addr) begin
                // read-only status words accept and drop writes
                next_state.bresp = flash_protect_pkg::resp_okay;
            end else begin
                next_state.bresp = flash_protect_pkg::resp_slverr;
            end
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // ----- read channel -----
        if (s_axi_arvalid && s_axi_arready) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = flash_protect_pkg::resp_okay;
            next_state.rdata = 32'h00000000;
            if (s_axi_araddr == flash_protect_pkg::security_mode_addr) begin
                next_state.rdata[flash_protect_pkg::security_enable_pos] =
                    state.security_enable_bit;
            end else if (s_axi_araddr ==
                         flash_protect_pkg::security_key_addr) begin
                next_state.rdata = 32'h00000000; // write-only reads zero
            end else if (s_axi_araddr ==
                         flash_protect_pkg::protect_status_addr) begin
                next_state.rdata[blocks-1:0] = protect_bits;
            end else if (s_axi_araddr == flash_protect_pkg::status_addr) begin
                next_state.rdata[flash_protect_pkg::st_secure_pos] =
                    state.secure;
                next_state.rdata[flash_protect_pkg::st_all_prot_pos] =
                    all_protected;
                next_state.rdata[flash_protect_pkg::st_probe_en_pos] =
                    !state.secure;
                next_state.rdata[flash_protect_pkg::st_prog_rd_pos] =
                    !all_protected;
            end else begin
                next_state.rresp = flash_protect_pkg::resp_slverr;
            end
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        // ----- security from protect cells -----
        if (load_image) begin
            next_state.powered_up = 1'b1;
            // power-up with all cells protected starts secure
            next_state.secure = &nv_protect_image;
        end else if (protect_cmd && (&(protect_bits | cmd_block_sel))) begin
            // protecting the last block turns security on
            next_state.secure = 1'b1;
        end

        // ----- program and erase gating -----
        for (int i = 0; i < blocks; i++) begin
            next_state.program_enable[i] = program_req && cmd_block_sel[i] &&
                !protect_bits[i];
            next_state.erase_enable[i] = (erase_req && cmd_block_sel[i] ||
                chip_erase_req) && !protect_bits[i];
        end
        next_state.op_refused = ((program_req || erase_req) &&
            |(cmd_block_sel & protect_bits)) ||
            (chip_erase_req && all_protected);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.security_enable_bit <=
                flash_protect_pkg::security_enable_reset;
            state.secure <= 1'b1;
        end else if (aclken) begin
            state <= next_state;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    // answers are hidden while frozen so no response is lost
    assign s_axi_bvalid = state.bvalid && aclken;
    assign s_axi_bresp = state.bresp;
    assign s_axi_rvalid = state.rvalid && aclken;
    assign s_axi_rresp = state.rresp;
    assign s_axi_rdata = state.rdata;
    assign program_enable = state.program_enable;
    assign erase_enable = state.erase_enable;
    assign op_refused = state.op_refused;
    assign secure_state = state.secure;
    // full protection blocks reads in programmer mode as well as every program and erase
    assign programmer_read_enable = programmer_mode && !all_protected;
    assign probe_access_enable = !state.secure;

    // probe pins are wired only to the debug unit, no port mux exists
    assign probe_tdi_core = probe_tdi;
    assign probe_tms_core = probe_tms;
    assign probe_tdo = probe_tdo_core;
    assign probe_tdo_oe = 1'b1;
endmodule // flash_block_protect_security

// ### verification/flash_guard_asserts.sv
// port assertions for the flash protection and security block
`timescale 1ns/1ps
module flash_guard_asserts #(
    parameter int blocks = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // flash command side
    input wire logic protect_cmd,
    input wire logic [blocks-1:0] cmd_block_sel,
    input wire logic program_req,
    input wire logic erase_req,
    input wire logic chip_erase_req,
    input wire logic [blocks-1:0] program_enable,
    input wire logic [blocks-1:0] erase_enable,
    input wire logic op_refused,
    // gates and bus answer
    input wire logic secure_state,
    input wire logic probe_access_enable,
    input wire logic s_axi_bvalid,
    // probe pins
    input wire logic probe_tdi,
    input wire logic probe_tms,
    input wire logic probe_tdo,
    input wire logic probe_tdo_oe,
    input wire logic probe_tdi_core,
    input wire logic probe_tms_core,
    input wire logic probe_tdo_core
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    probe_gate_a: assert property (
        probe_access_enable == !secure_state)
        else $error("probe access disagrees with secure state");
    probe_pins_a: assert property (
        probe_tdo_oe && probe_tdo == probe_tdo_core
        && probe_tdi_core == probe_tdi && probe_tms_core == probe_tms)
        else $error("probe pins not passed straight through");
    prog_cause_a: assert property (|program_enable |-> $past(program_req))
        else $error("program enable without request");
    erase_cause_a: assert property (|erase_enable
        |-> $past(erase_req || chip_erase_req))
        else $error("erase enable without request");
    prog_select_a: assert property (program_req |=>
        (program_enable & ~$past(cmd_block_sel)) == '0)
        else $error("program enable outside selection");
    refuse_cause_a: assert property (op_refused
        |-> $past(program_req || erase_req || chip_erase_req))
        else $error("refusal without request");
    unlock_path_a: assert property (
        $fell(secure_state) && $past(aresetn, 2)
        |-> $rose(s_axi_bvalid))
        else $error("security lifted without register write");
    lock_path_a: assert property (
        $rose(secure_state) && $past(aresetn, 2)
        |-> $rose(s_axi_bvalid) || $past(protect_cmd))
        else $error("security set without cause");
endmodule // flash_guard_asserts

bind flash_block_protect_security flash_guard_asserts #(.blocks(blocks))
    i_flash_guard_asserts (
    .aclk, .aresetn, .protect_cmd, .cmd_block_sel, .program_req, .erase_req,
    .chip_erase_req, .program_enable, .erase_enable, .op_refused,
    .secure_state, .probe_access_enable, .s_axi_bvalid, .probe_tdi, .probe_tms,
    .probe_tdo, .probe_tdo_oe, .probe_tdi_core, .probe_tms_core,
    .probe_tdo_core);

// ### verification/debug_probe_model.sv
// external debug probe driving its dedicated pins
`timescale 1ns/1ps
module debug_probe_model (
    // clock
    input wire logic aclk,
    // probe pins
    input wire logic probe_tdo,
    output logic probe_tdi,
    output logic probe_tms
);
    // ****************************************
    // pin pattern
    // ****************************************
    logic [1:0] cnt = 2'h0;
    // pattern changes every cycle so a stuck pass-through shows
    always @(posedge aclk) begin
        cnt <= cnt + 2'h1 + {1'h0, probe_tdo};
    end
    assign probe_tdi = cnt[0];
    assign probe_tms = cnt[1];
endmodule // debug_probe_model

// ### verification/flash_block_protect_security_test.sv
// self-checking bench for the flash protection and security block
`timescale 1ns/1ps
module flash_block_protect_security_test;
    // ****************************************
    // signals and instances
    // ****************************************
    logic aclk = 0, aresetn = 0, aclken = 1, s_axi_awvalid = 0;
    logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, protect_cmd = 0, unprotect_all_cmd = 0;
    logic program_req = 0, erase_req = 0, chip_erase_req = 0;
    logic programmer_mode = 0, probe_tdo_core = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] nv_protect_image = 8'hff, cmd_block_sel = 8'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, op_refused, programmer_read_enable;
    logic probe_access_enable, secure_state, probe_tdi, probe_tms;
    logic probe_tdo, probe_tdo_oe, probe_tdi_core, probe_tms_core;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] program_enable, erase_enable;
    int num_errors = 0, check_count = 0;
    flash_block_protect_security i_flash_block_protect_security (
        .aclk, .aresetn, .aclken, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_protect_image,
        .protect_cmd, .unprotect_all_cmd, .cmd_block_sel, .program_req,
        .erase_req, .chip_erase_req, .program_enable, .erase_enable,
        .op_refused, .programmer_mode, .programmer_read_enable,
        .probe_access_enable, .secure_state, .probe_tdi, .probe_tms,
        .probe_tdo, .probe_tdo_oe, .probe_tdi_core, .probe_tms_core,
        .probe_tdo_core);
    debug_probe_model i_debug_probe_model (.aclk, .probe_tdo, .probe_tdi,
        .probe_tms);
    always #5 aclk = ~aclk;
    always @(posedge aclk) probe_tdo_core <= ~probe_tdo_core;
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    task automatic test_done;
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic rst(input logic [7:0] img);
        @(posedge aclk);
        aresetn <= 0;
        nv_protect_image <= img;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        #1;
    endtask
    // one write; address and data offered together, released when taken
    task automatic wr(input logic [31:0] a, d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 0;
        chk("bresp", s_axi_bresp, 2'h0);
        #1;
    endtask
    task automatic rd(input logic [31:0] a, e, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 0;
        chk("rresp", s_axi_rresp, r);
        if (r == 2'h0) chk("rdata", s_axi_rdata, e);
    endtask
    // one-cycle command pulse; results stand for the next cycle only
    task automatic op(input logic [4:0] k, input logic [7:0] s);
        @(posedge aclk);
        {protect_cmd, unprotect_all_cmd, program_req, erase_req,
            chip_erase_req} <= k;
        cmd_block_sel <= s;
        @(posedge aclk);
        {protect_cmd, unprotect_all_cmd, program_req, erase_req,
            chip_erase_req} <= 5'h00;
        #1;
    endtask
    task automatic t_unlock;
        rd(flash_protect_pkg::security_mode_addr, 32'h1, 2'h0);
        rd(32'hffffe520, 32'h0, flash_protect_pkg::resp_slverr);
        wr(flash_protect_pkg::security_mode_addr, 32'hfffffffe);
        rd(flash_protect_pkg::security_mode_addr, 32'h0, 2'h0);
        wr(flash_protect_pkg::security_key_addr, 32'h000001c5);
        chk("secure", secure_state, 1'h1);
        s_axi_wstrb <= 4'h7;
        wr(flash_protect_pkg::security_key_addr, 32'h000000c5);
        chk("secure", secure_state, 1'h1);
        s_axi_wstrb <= 4'hf;
        wr(flash_protect_pkg::security_key_addr, 32'h000000c5);
        chk("secure", secure_state, 1'h0);
        chk("probe", probe_access_enable, 1'h1);
        rd(flash_protect_pkg::security_key_addr, 32'h0, 2'h0);
    endtask
    task automatic t_flash;
        programmer_mode <= 1;
        op(5'h04, 8'h01);
        chk("refused", op_refused, 1'h1);
        chk("prog_en", program_enable, 8'h00);
        chk("prog_read", programmer_read_enable, 1'h0);
        op(5'h08, 8'h00);
        chk("prog_read", programmer_read_enable, 1'h1);
        op(5'h10, 8'h0f);
        op(5'h01, 8'h00);
        chk("chip_erase", erase_enable, 8'hf0);
        op(5'h02, 8'h11);
        chk("erase_en", erase_enable, 8'h10);
        chk("refused", op_refused, 1'h1);
        op(5'h04, 8'h80);
        chk("prog_en", program_enable, 8'h80);
        chk("refused", op_refused, 1'h0);
        op(5'h10, 8'hf0);
        chk("secure", secure_state, 1'h1);
        chk("probe", probe_access_enable, 1'h0);
    endtask
    task automatic t_relock;
        wr(flash_protect_pkg::security_mode_addr, 32'h0);
        wr(flash_protect_pkg::security_key_addr, 32'h000000c5);
        chk("secure", secure_state, 1'h0);
        wr(flash_protect_pkg::security_mode_addr, 32'h1);
        wr(flash_protect_pkg::security_key_addr, 32'h000000c5);
        chk("secure", secure_state, 1'h1);
    endtask
    // frozen cycles take no command and no bus transfer
    task automatic t_hold;
        aclken <= 0;
        op(5'h04, 8'h01);
        chk("refused", op_refused, 1'h0);
        chk("awready", s_axi_awready, 1'h0);
        aclken <= 1;
        op(5'h04, 8'h01);
        chk("refused", op_refused, 1'h1);
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        rst(8'hff);
        chk("secure", secure_state, 1'h1);
        rd(flash_protect_pkg::status_addr, 32'h3, 2'h0);
        chk("probe", probe_access_enable, 1'h0);
        t_unlock;
        t_flash;
        t_relock;
        t_hold;
        rst(8'h0f);
        chk("secure", secure_state, 1'h0);
        rd(flash_protect_pkg::protect_status_addr, 32'h0f, 2'h0);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        test_done;
    end
endmodule // flash_block_protect_security_test
